// ---- hdl/ref_trim_map.svh ----
`ifndef REF_TRIM_MAP_SVH
`define REF_TRIM_MAP_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_PROTOCOL_REVISION   8'h98
`define CMD_USER_SCRATCH_WORD   8'hd0
`define CMD_TRIM_SLOT           8'hd4
`define CMD_MARGIN_HIGH_SLOT    8'hd5

// ------------------------------------------------------------
// Reset and fixed values
// ------------------------------------------------------------
`define PROTOCOL_REVISION_VAL   8'h11
`define RST_USER_SCRATCH        16'h0000
`define RST_TRIM                8'h00
`define RST_MARGIN_HIGH_STEP    5'h1e

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define TRIM_FIELD_MSB          7
`define STEP_FIELD_MSB          4

// ------------------------------------------------------------
// Spans in millivolts, one code is one LSB
// ------------------------------------------------------------
`define REF_LSB_MV              2
`define TRIM_MIN_MV             (-120)
`define TRIM_MAX_MV             60
`define STEP_MIN_MV             0
`define STEP_MAX_MV             60
`define SUM_MIN_MV              (-180)
`define SUM_MAX_MV              60

// ------------------------------------------------------------
// Slew timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS           10
`define RAMP_BASE_NS            1000
`define RAMP_BASE_CYCLES        (`RAMP_BASE_NS / `CLK_PERIOD_NS)
`define RISE_CODE_MAX           3'h7

`endif

// ---- hdl/ref_trim_pkg.sv ----
package ref_trim_pkg;

  // Slew engine states, Gray along idle -> up -> down
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'h0,
    RAMP_UP   = 2'h1,
    RAMP_DOWN = 2'h3
  } ramp_state_t;

  typedef logic signed [9:0] ref_code_t;

  typedef struct packed {
    ramp_state_t state;
    ref_code_t   level;
    logic [15:0] cnt;
  } ramp_regs_t;

  typedef struct packed {
    logic [15:0]       scratch;
    logic [1:0][7:0]   trim;
    logic [1:0][4:0]   step;
    logic [15:0]       rd_data;
    logic              rd_hit;
    logic              alert;
    logic              store_valid;
    logic [15:0]       nvm_scratch;
    logic [1:0][7:0]   nvm_trim;
    logic [1:0][4:0]   nvm_step;
  } bank_regs_t;

endpackage

// ---- hdl/ref_ramp_if.sv ----
`timescale 1ns/100ps

// Target and rate in, live reference out
interface ref_ramp_if;
  ref_trim_pkg::ref_code_t target;
  logic [2:0]              rise_code;
  ref_trim_pkg::ref_code_t level;
  logic                    settled;

  modport ctrl (output target, output rise_code, input level, input settled);
  modport ramp (input target, input rise_code, output level, output settled);
endinterface

// ---- hdl/ref_ramp.sv ----
`timescale 1ns/100ps
`include "ref_trim_map.svh"

module ref_ramp #(
  parameter int unsigned BASE_CYCLES = `RAMP_BASE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  ref_ramp_if.ramp  port
);

  ref_trim_pkg::ramp_regs_t r;
  ref_trim_pkg::ramp_regs_t next_r;
  logic [15:0]              period;

  // One LSB step every period cycles, period doubles per rise code
  assign period = 16'(BASE_CYCLES << port.rise_code);

  // ------------------------------------------------------------
  // Slew toward target
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    case (r.state)
      ref_trim_pkg::RAMP_IDLE: begin
        next_r.cnt = 16'h0000;
        if (port.target > r.level) begin
          next_r.state = ref_trim_pkg::RAMP_UP;
        end else if (port.target < r.level) begin
          next_r.state = ref_trim_pkg::RAMP_DOWN;
        end
      end
      ref_trim_pkg::RAMP_UP,
      ref_trim_pkg::RAMP_DOWN: begin
        if (port.target == r.level) begin
          next_r.state = ref_trim_pkg::RAMP_IDLE;
          next_r.cnt   = 16'h0000;
        end else if (r.cnt >= period - 16'h0001) begin
          next_r.cnt   = 16'h0000;
          next_r.level = (port.target > r.level) ? r.level + 10'sh001
                                                 : r.level - 10'sh001;
          next_r.state = (port.target > r.level) ? ref_trim_pkg::RAMP_UP
                                                 : ref_trim_pkg::RAMP_DOWN;
        end else begin
          next_r.cnt = r.cnt + 16'h0001;
        end
      end
      default: begin
        next_r.state = ref_trim_pkg::RAMP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{state: ref_trim_pkg::RAMP_IDLE, level: 10'sh000, cnt: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  assign port.level   = r.level;
  assign port.settled = (r.state == ref_trim_pkg::RAMP_IDLE) && (port.target == r.level);

endmodule

// ---- hdl/ref_trim_margin_regs.sv ----
`timescale 1ns/100ps
`include "ref_trim_map.svh"

// Behaviour
// - Reading the revision command returns the fixed byte for protocol revision 1.1.
// - The scratch word is a plain 16-bit read/write store that resets to zero.
// - Scratch, trim and margin-high step are all copied out on a store-all request.
// - The trim adds its two's complement value times 2 mV to the reference target.
// - The trim accepts -120 mV to +60 mV in 2 mV codes.
// - An out-of-span trim or step write is clamped to the nearer limit.
// - Any out-of-span write raises the alert, the fault flag and the invalid-data flag.
// - Trim plus step is held within -180 mV to +60 mV, with clamp and flags beyond.
// - During soft-start the reference slews at the programmed rise-time rate.
// - After soft-start every reference change slews at the slowest rise-time rate.
// - Selecting margin high moves the reference to the margin-high target.
// - The margin-high offset is step plus trim, times 2 mV.
// - The margin-high step accepts 0 to 60 mV and only its five low bits are writable.
// - The margin-high step resets to 30, an offset of 60 mV.
// - Trim and step are kept per channel and the page picks the copy accessed.
module ref_trim_margin_regs #(
  parameter int unsigned NUM_CH           = 2,
  parameter int unsigned RAMP_BASE_CYCLES = `RAMP_BASE_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic [7:0]              cmd_code,
  input  wire logic                    cmd_page,
  input  wire logic                    wr_strobe,
  input  wire logic [15:0]             wr_data,
  output logic [15:0]                  rd_data,
  output logic                         rd_hit,
  input  wire logic                    store_all,
  output logic                         nvm_store_valid,
  output logic [15:0]                  nvm_scratch,
  output logic [NUM_CH-1:0][7:0]       nvm_trim,
  output logic [NUM_CH-1:0][4:0]       nvm_step,
  input  wire logic [NUM_CH-1:0]       margin_high,
  input  wire logic [NUM_CH-1:0]       soft_start_done,
  input  wire logic [NUM_CH-1:0][2:0]  rise_code,
  output logic [NUM_CH-1:0][9:0]       ref_offset,
  output logic [NUM_CH-1:0]            ref_settled,
  output logic                         smbalert_set,
  output logic                         cml_fault_set,
  output logic                         invalid_data_set
);

  // ------------------------------------------------------------
  // Limits in LSB codes
  // ------------------------------------------------------------
  localparam ref_trim_pkg::ref_code_t TRIM_MIN = 10'(`TRIM_MIN_MV / `REF_LSB_MV);
  localparam ref_trim_pkg::ref_code_t TRIM_MAX = 10'(`TRIM_MAX_MV / `REF_LSB_MV);
  localparam ref_trim_pkg::ref_code_t STEP_MIN = 10'(`STEP_MIN_MV / `REF_LSB_MV);
  localparam ref_trim_pkg::ref_code_t STEP_MAX = 10'(`STEP_MAX_MV / `REF_LSB_MV);
  localparam ref_trim_pkg::ref_code_t SUM_MIN  = 10'(`SUM_MIN_MV / `REF_LSB_MV);
  localparam ref_trim_pkg::ref_code_t SUM_MAX  = 10'(`SUM_MAX_MV / `REF_LSB_MV);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Signed saturation of a code into [lo, hi]
  function automatic logic signed [16:0] clamp17(
    input logic signed [16:0] v,
    input logic signed [16:0] lo,
    input logic signed [16:0] hi
  );
    logic signed [16:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction

  // Widen a 10-bit limit code to 17 bits
  function automatic logic signed [16:0] wide(input ref_trim_pkg::ref_code_t v);
    return 17'(v);
  endfunction

  // ------------------------------------------------------------
  // Register bank state
  // ------------------------------------------------------------
  ref_trim_pkg::bank_regs_t r;
  ref_trim_pkg::bank_regs_t next_r;

  logic signed [16:0] wr_val;
  logic signed [16:0] cur_trim;
  logic signed [16:0] cur_step;
  logic signed [16:0] new_trim;
  logic signed [16:0] new_step;
  logic signed [16:0] new_sum;
  logic               trim_range_bad;
  logic               step_range_bad;
  logic               sum_bad;
  logic               wr_trim;
  logic               wr_step;
  logic [15:0]        rd_mux;
  logic               rd_known;

  // Write value and the paged copies it meets
  assign wr_val   = 17'(signed'(wr_data));
  assign cur_trim = 17'(signed'(r.trim[cmd_page]));
  assign cur_step = 17'(signed'({1'b0, r.step[cmd_page]}));
  assign wr_trim  = wr_strobe && (cmd_code == `CMD_TRIM_SLOT);
  assign wr_step  = wr_strobe && (cmd_code == `CMD_MARGIN_HIGH_SLOT);

  // Span checks for trim and step writes
  assign new_trim       = clamp17(wr_val, wide(TRIM_MIN), wide(TRIM_MAX));
  assign new_step       = clamp17(wr_val, wide(STEP_MIN), wide(STEP_MAX));
  assign trim_range_bad = (new_trim != wr_val);
  assign step_range_bad = (new_step != wr_val);

  // Sum of the values that would stand after the write
  always_comb begin
    new_sum = cur_trim + cur_step;
    if (wr_trim) begin
      new_sum = new_trim + cur_step;
    end else if (wr_step) begin
      new_sum = cur_trim + new_step;
    end
  end

  assign sum_bad = (new_sum < wide(SUM_MIN)) || (new_sum > wide(SUM_MAX));

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  // Read mux on command code and page
  always_comb begin
    rd_mux   = 16'h0000;
    rd_known = 1'b1;
    case (cmd_code)
      `CMD_PROTOCOL_REVISION: begin
        rd_mux = {8'h00, `PROTOCOL_REVISION_VAL};
      end
      `CMD_USER_SCRATCH_WORD: begin
        rd_mux = r.scratch;
      end
      `CMD_TRIM_SLOT: begin
        rd_mux = 16'(signed'(r.trim[cmd_page]));
      end
      `CMD_MARGIN_HIGH_SLOT: begin
        rd_mux = {11'h000, r.step[cmd_page]};
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------

  // Writes, clamping, flags and store snapshot
  always_comb begin
    next_r             = r;
    next_r.rd_data     = rd_mux;
    next_r.rd_hit      = rd_known;
    next_r.alert       = 1'b0;
    next_r.store_valid = 1'b0;

    // Scratch word, all bits writable
    if (wr_strobe && (cmd_code == `CMD_USER_SCRATCH_WORD)) begin
      next_r.scratch = wr_data;
    end

    // Trim, only the low field stored, rest read as sign
    if (wr_trim) begin
      next_r.trim[cmd_page] = new_trim[`TRIM_FIELD_MSB:0];
      next_r.alert          = trim_range_bad || sum_bad;
    end

    // Margin-high step, five writable bits
    if (wr_step) begin
      next_r.step[cmd_page] = new_step[`STEP_FIELD_MSB:0];
      next_r.alert          = step_range_bad || sum_bad;
    end

    // Snapshot for the nonvolatile store
    if (store_all) begin
      next_r.store_valid = 1'b1;
      next_r.nvm_scratch = r.scratch;
      next_r.nvm_trim    = r.trim;
      next_r.nvm_step    = r.step;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------

  // Power-on values
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.scratch     <= `RST_USER_SCRATCH;
      r.trim        <= {2{`RST_TRIM}};
      r.step        <= {2{`RST_MARGIN_HIGH_STEP}};
      r.rd_data     <= 16'h0000;
      r.rd_hit      <= 1'b0;
      r.alert       <= 1'b0;
      r.store_valid <= 1'b0;
      r.nvm_scratch <= 16'h0000;
      r.nvm_trim    <= '0;
      r.nvm_step    <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Register outputs
  // ------------------------------------------------------------

  // Read data and store snapshot
  assign rd_data          = r.rd_data;
  assign rd_hit           = r.rd_hit;
  assign nvm_store_valid  = r.store_valid;
  assign nvm_scratch      = r.nvm_scratch;
  assign nvm_trim         = r.nvm_trim;
  assign nvm_step         = r.nvm_step;

  // One alert event drives all three status pulses
  assign smbalert_set     = r.alert;
  assign cml_fault_set    = r.alert;
  assign invalid_data_set = r.alert;

  // ------------------------------------------------------------
  // Per-channel reference targets and slew
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      ref_ramp_if         rif();
      logic signed [16:0] sum;

      // Trim alone, or trim plus step in margin high
      assign sum = 17'(signed'(r.trim[ch]))
                 + (margin_high[ch] ? 17'(signed'({1'b0, r.step[ch]}))
                                    : 17'h0_0000);

      // Clamp target into the net window
      assign rif.target = 10'(clamp17(sum, wide(SUM_MIN), wide(SUM_MAX)));

      // Programmed rate in soft-start, slowest rate after
      assign rif.rise_code = soft_start_done[ch] ? `RISE_CODE_MAX
                                                 : rise_code[ch];

      ref_ramp #(
        .BASE_CYCLES (RAMP_BASE_CYCLES)
      ) u_ramp (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .port     (rif.ramp)
      );

      assign ref_offset[ch]  = rif.level;
      assign ref_settled[ch] = rif.settled;
    end
  endgenerate

endmodule

// ---- sim/ref_trim_margin_regs_asserts.sv ----
`timescale 1ns/100ps

module ref_trim_margin_regs_asserts #(
  parameter int unsigned NUM_CH           = 2,
  parameter int unsigned RAMP_BASE_CYCLES = 2
) (
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire logic [7:0]              cmd_code,
  input wire logic                    wr_strobe,
  input wire logic                    store_all,
  input wire logic [15:0]             rd_data,
  input wire logic                    rd_hit,
  input wire logic                    nvm_store_valid,
  input wire logic [15:0]             nvm_scratch,
  input wire logic [NUM_CH-1:0][7:0]  nvm_trim,
  input wire logic [NUM_CH-1:0][4:0]  nvm_step,
  input wire logic [NUM_CH-1:0][9:0]  ref_offset,
  input wire logic                    smbalert_set,
  input wire logic                    cml_fault_set,
  input wire logic                    invalid_data_set
);
  logic [1:0] up_cnt;
  logic       live;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Edges since release, covers the reset synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  assign live = (up_cnt == 2'h3);

  alert_cause_a:
  assert property (smbalert_set |-> $past(wr_strobe) &&
    ($past(cmd_code) == 8'hd4 || $past(cmd_code) == 8'hd5))
    else $error("alert without trim or step write");
  flags_same_a:
  assert property ((smbalert_set == cml_fault_set) && (smbalert_set == invalid_data_set))
    else $error("alert and status pulses differ");
  store_cause_a:
  assert property (nvm_store_valid |-> $past(store_all))
    else $error("snapshot without request");
  store_hold_a:
  assert property (!nvm_store_valid |->
    $stable(nvm_scratch) && $stable(nvm_trim) && $stable(nvm_step))
    else $error("snapshot changed without store");
  rev_read_a:
  assert property (live && $past(cmd_code) == 8'h98 |-> rd_hit && rd_data == 16'h0011)
    else $error("revision readout wrong");
  trim_sign_a:
  assert property (live && $past(cmd_code) == 8'hd4 |-> rd_data[15:8] == {8{rd_data[7]}})
    else $error("trim upper byte not sign fill");
  step_zero_a:
  assert property (live && $past(cmd_code) == 8'hd5 |->
    rd_data[15:5] == 11'h000 && rd_data[4:0] <= 5'h1e)
    else $error("step readout out of field");
  miss_read_a:
  assert property (live && !($past(cmd_code) inside {8'h98, 8'hd0, 8'hd4, 8'hd5}) |->
    !rd_hit && rd_data == 16'h0000)
    else $error("unknown command answered");
  ref_span_a:
  assert property ($signed(ref_offset[0]) >= -90 && $signed(ref_offset[0]) <= 30 &&
    $signed(ref_offset[1]) >= -90 && $signed(ref_offset[1]) <= 30)
    else $error("reference outside net window");
  ref_rate_a:
  assert property ($changed(ref_offset[0]) |->
    ($signed(ref_offset[0]) - $signed($past(ref_offset[0])) inside {-1, 1})
    ##1 $stable(ref_offset[0]))
    else $error("reference step too large or fast");

  // Main scenarios seen
  cover property (smbalert_set);
  cover property (nvm_store_valid);
  cover property ($changed(ref_offset[0]));
endmodule

bind ref_trim_margin_regs ref_trim_margin_regs_asserts #(
  .NUM_CH           (NUM_CH),
  .RAMP_BASE_CYCLES (RAMP_BASE_CYCLES)
) u_asserts (.core_clk, .resetn, .cmd_code, .wr_strobe, .store_all, .rd_data, .rd_hit,
  .nvm_store_valid, .nvm_scratch, .nvm_trim, .nvm_step, .ref_offset, .smbalert_set,
  .cml_fault_set, .invalid_data_set);

// ---- sim/pmbus_host_model.sv ----
`timescale 1ns/100ps

module pmbus_host_model (
  input  wire logic        core_clk,
  output logic [7:0]       cmd_code,
  output logic             cmd_page,
  output logic             wr_strobe,
  output logic [15:0]      wr_data,
  output logic             store_all,
  input  wire logic [15:0] rd_data,
  input  wire logic        invalid_data_set
);
  logic flagged;

  // Idle bus at time zero
  initial begin
    cmd_code = 8'h00;
    cmd_page = 1'b0;
    wr_strobe = 1'b0;
    wr_data = 16'h0000;
    store_all = 1'b0;
    flagged = 1'b0;
  end

  // Page goes with the command, invalid data sampled after the write
  task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d);
    @(negedge core_clk);
    cmd_code = c;
    cmd_page = p;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge core_clk);
    wr_strobe = 1'b0;
    wr_data = ~d;
    flagged = invalid_data_set;
  endtask

  // Registered read, one cycle lag
  task automatic rd(input logic [7:0] c, input logic p, output logic [15:0] d);
    @(negedge core_clk);
    cmd_code = c;
    cmd_page = p;
    @(negedge core_clk);
    d = rd_data;
  endtask

  // One cycle snapshot request
  task automatic store();
    @(negedge core_clk);
    store_all = 1'b1;
    @(negedge core_clk);
    store_all = 1'b0;
  endtask
endmodule

// ---- sim/test_reference_trim_margin_registers.sv ----
`timescale 1ns/100ps

module test_reference_trim_margin_registers;
  logic                core_clk = 1'b0;
  logic                resetn;
  logic [7:0]          cmd_code;
  logic                cmd_page;
  logic                wr_strobe;
  logic [15:0]         wr_data;
  logic [15:0]         rd_data;
  logic                rd_hit;
  logic                store_all;
  logic                nvm_store_valid;
  logic [15:0]         nvm_scratch;
  logic [1:0][7:0]     nvm_trim;
  logic [1:0][4:0]     nvm_step;
  logic [1:0]          margin_high;
  logic [1:0]          soft_start_done;
  logic [1:0][2:0]     rise_code;
  logic [1:0][9:0]     ref_offset;
  logic [1:0]          ref_settled;
  logic                smbalert_set;
  logic                cml_fault_set;
  logic                invalid_data_set;
  logic [15:0]         got;
  int                  num_errors = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  int                  n;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  ref_trim_margin_regs #(.NUM_CH(2), .RAMP_BASE_CYCLES(2)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
    .store_all(store_all), .nvm_store_valid(nvm_store_valid), .nvm_scratch(nvm_scratch),
    .nvm_trim(nvm_trim), .nvm_step(nvm_step), .margin_high(margin_high),
    .soft_start_done(soft_start_done), .rise_code(rise_code), .ref_offset(ref_offset),
    .ref_settled(ref_settled), .smbalert_set(smbalert_set), .cml_fault_set(cml_fault_set),
    .invalid_data_set(invalid_data_set));

  pmbus_host_model u_host (
    .core_clk(core_clk), .cmd_code(cmd_code), .cmd_page(cmd_page), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .store_all(store_all), .rd_data(rd_data),
    .invalid_data_set(invalid_data_set));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_n(input int g, input int lo, input int hi);
    cmp_count++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("[FAIL] %0t cycles %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Write, check the invalid data pulse, read back
  task automatic wrchk(input logic [7:0] c, input logic p, input logic [15:0] d,
                       input logic a, input logic [15:0] e);
    u_host.wr(c, p, d);
    chk16({15'h0000, u_host.flagged}, {15'h0000, a});
    u_host.rd(c, p, got);
    chk16(got, e);
  endtask

  // Cycles until channel 0 reaches a level
  task automatic wait_ref(input logic [9:0] t, output int k);
    k = 0;
    while (ref_offset[0] !== t && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    margin_high = 2'h0;
    soft_start_done = 2'h0;
    rise_code = 6'h18;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    u_host.rd(8'h98, 1'b0, got);
    chk16(got, 16'h0011);
    u_host.rd(8'hd0, 1'b0, got);
    chk16(got, 16'h0000);
    u_host.rd(8'hd5, 1'b1, got);
    chk16(got, 16'h001e);
    u_host.rd(8'h55, 1'b0, got);
    chk16(got, 16'h0000);
    wrchk(8'h98, 1'b0, 16'h1234, 1'b0, 16'h0011);
    wrchk(8'hd0, 1'b0, 16'ha5c3, 1'b0, 16'ha5c3);
    wrchk(8'hd4, 1'b1, 16'hffc4, 1'b0, 16'hffc4);
    wrchk(8'hd4, 1'b1, 16'hff00, 1'b1, 16'hffc4);
    wrchk(8'hd5, 1'b0, 16'h0000, 1'b0, 16'h0000);
    wrchk(8'hd4, 1'b0, 16'h001f, 1'b1, 16'h001e);
    wrchk(8'hd4, 1'b0, 16'h001e, 1'b0, 16'h001e);
    wrchk(8'hd5, 1'b0, 16'h0001, 1'b1, 16'h0001);
    wrchk(8'hd5, 1'b0, 16'h0020, 1'b1, 16'h001e);
    wrchk(8'hd5, 1'b0, 16'hffe0, 1'b1, 16'h0000);
    u_host.rd(8'hd5, 1'b1, got);
    chk16(got, 16'h001e);
    u_host.store();
    chk16({15'h0000, nvm_store_valid}, 16'h0001);
    chk16(nvm_scratch, 16'ha5c3);
    chk16(nvm_trim, 16'hc41e);
    chk16({6'h00, nvm_step}, {6'h00, 5'h1e, 5'h00});
    u_host.wr(8'hd4, 1'b0, 16'hfff6);
    wait_ref(10'h3f6, n);
    chk_n(n, 0, 200);
    soft_start_done = 2'h1;
    u_host.wr(8'hd5, 1'b0, 16'h0005);
    margin_high = 2'h1;
    wait_ref(10'h3fb, n);
    chk_n(n, 1280, 1300);
    @(negedge core_clk);
    chk16({15'h0000, ref_settled[0]}, 16'h0001);
    finish_test();
  end
endmodule
